// *** hdl/rpf_queues.sv ***
// payload queues, width settings and queue status of the radio
`timescale 1ns/1ps

module rpf_queues (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // controller command port
  input  wire logic              cmd_valid,
  input  wire rpf_pkg::rpf_cmd_t cmd,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output rpf_pkg::rpf_entry_t    rx_out,
  output logic                   rx_out_valid,
  // transceiver mode and features
  input  wire logic              rx_mode,
  input  wire logic              ack_pay_en,
  output logic [5:0]             pipe4_rx_width,
  output logic [5:0]             pipe5_rx_width,
  // radio receive side
  input  wire logic              rx_push,
  input  wire rpf_pkg::rpf_entry_t rx_in,
  input  wire logic              ack_take,
  input  wire logic [2:0]        ack_pipe,
  output rpf_pkg::rpf_entry_t    ack_out,
  output logic                   ack_out_valid,
  // radio transmit side
  input  wire logic              tx_take,
  output rpf_pkg::rpf_entry_t    tx_out,
  output logic                   tx_out_valid
);

  rpf_pkg::rpf_state_t st;
  rpf_pkg::rpf_state_t next_st;
  logic [7:0]          qstat;
  logic                ack_hit;
  logic [1:0]          ack_idx;

  // status is built from the registered counts, so it lags a change by one
  always_comb begin
    qstat = 8'h00;
    qstat[rpf_pkg::REUSE_BIT]    = st.reuse;
    qstat[rpf_pkg::TX_FULL_BIT]  = (st.txn == rpf_pkg::QFULL);
    qstat[rpf_pkg::TX_EMPTY_BIT] = (st.txn == 2'h0);
    qstat[rpf_pkg::RX_FULL_BIT]  = (st.rxn == rpf_pkg::QFULL);
    qstat[rpf_pkg::RX_EMPTY_BIT] = (st.rxn == 2'h0);
  end

  // oldest pending acknowledgement for the requested pipe
  always_comb begin
    ack_hit = 1'b0;
    ack_idx = 2'h0;
    for (int i = rpf_pkg::QDEPTH - 1; i >= 0; i--) begin
      if ((2'(i) < st.ackn) && (st.ackq[i].pipe == ack_pipe)) begin
        ack_hit = 1'b1;
        ack_idx = 2'(i);
      end
    end
  end

  always_comb begin
    next_st               = st;
    next_st.rd_valid      = 1'b0;
    next_st.rx_out_valid  = 1'b0;
    next_st.tx_out_valid  = 1'b0;
    next_st.ack_out_valid = 1'b0;

    // radio takes a transmit payload; a repeat leaves the queue alone
    if (tx_take && !rx_mode) begin
      if (st.reuse) begin
        next_st.tx_out       = st.last;
        next_st.tx_out_valid = 1'b1;
      end else if (st.txn != 2'h0) begin
        next_st.tx_out       = st.txq[0];
        next_st.last         = st.txq[0];
        next_st.tx_out_valid = 1'b1;
        for (int i = 0; i < rpf_pkg::QDEPTH - 1; i++) begin
          next_st.txq[i] = st.txq[i+1];
        end
        next_st.txn = st.txn - 2'h1;
      end
    end

    // radio attaches an acknowledgement payload, receive mode only
    if (ack_take && rx_mode && ack_hit) begin
      next_st.ack_out       = st.ackq[ack_idx];
      next_st.ack_out_valid = 1'b1;
      for (int i = 0; i < rpf_pkg::QDEPTH - 1; i++) begin
        if (2'(i) >= ack_idx) begin
          next_st.ackq[i] = st.ackq[i+1];
        end
      end
      next_st.ackn = st.ackn - 2'h1;
    end

    if (cmd_valid) begin
      case (cmd.op)
        rpf_pkg::CMD_REG_RD: begin
          next_st.rd_valid = 1'b1;
          case (cmd.addr)
            rpf_pkg::PIPE4_WIDTH_OFS: next_st.rd_data = {2'b00, st.p4w};
            rpf_pkg::PIPE5_WIDTH_OFS: next_st.rd_data = {2'b00, st.p5w};
            rpf_pkg::QSTAT_OFS:       next_st.rd_data = qstat;
            default:                  next_st.rd_data = 8'h00;
          endcase
        end
        rpf_pkg::CMD_REG_WR: begin
          // reserved bits are dropped, values above 32 are stored as given
          if (cmd.addr == rpf_pkg::PIPE4_WIDTH_OFS) begin
            next_st.p4w = cmd.wdata[rpf_pkg::WIDTH_BITS-1:0];
          end
          if (cmd.addr == rpf_pkg::PIPE5_WIDTH_OFS) begin
            next_st.p5w = cmd.wdata[rpf_pkg::WIDTH_BITS-1:0];
          end
        end
        rpf_pkg::CMD_W_TX: begin
          next_st.reuse = 1'b0;
          // full check after the pop, so a same-cycle take frees a slot
          if (next_st.txn != rpf_pkg::QFULL) begin
            next_st.txq[next_st.txn] = cmd.pld;
            next_st.txn = next_st.txn + 2'h1;
          end
        end
        rpf_pkg::CMD_W_ACK: begin
          if (ack_pay_en && (cmd.pld.pipe <= rpf_pkg::LAST_PIPE)
              && (next_st.ackn != rpf_pkg::QFULL)) begin
            next_st.ackq[next_st.ackn] = cmd.pld;
            next_st.ackn = next_st.ackn + 2'h1;
          end
        end
        rpf_pkg::CMD_REUSE: begin
          next_st.reuse = 1'b1;
        end
        rpf_pkg::CMD_FLUSH_TX: begin
          next_st.txn   = 2'h0;
          next_st.reuse = 1'b0;
        end
        rpf_pkg::CMD_FLUSH_RX: begin
          next_st.rxn = 2'h0;
        end
        rpf_pkg::CMD_R_RX: begin
          if (st.rxn != 2'h0) begin
            next_st.rx_out       = st.rxq[0];
            next_st.rx_out_valid = 1'b1;
            for (int i = 0; i < rpf_pkg::QDEPTH - 1; i++) begin
              next_st.rxq[i] = st.rxq[i+1];
            end
            next_st.rxn = st.rxn - 2'h1;
          end
        end
        default: begin
        end
      endcase
    end

    // received payload lands after any pop; dropped when the queue is full
    if (rx_push && (next_st.rxn != rpf_pkg::QFULL)) begin
      next_st.rxq[next_st.rxn] = rx_in;
      next_st.rxn = next_st.rxn + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st     <= '0;
      st.p4w <= rpf_pkg::WIDTH_RST;
      st.p5w <= rpf_pkg::WIDTH_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data        = st.rd_data;
  assign rd_valid       = st.rd_valid;
  assign rx_out         = st.rx_out;
  assign rx_out_valid   = st.rx_out_valid;
  assign tx_out         = st.tx_out;
  assign tx_out_valid   = st.tx_out_valid;
  assign ack_out        = st.ack_out;
  assign ack_out_valid  = st.ack_out_valid;
  assign pipe4_rx_width = st.p4w;
  assign pipe5_rx_width = st.p5w;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic is_rd_stat;
  assign is_rd_stat = cmd_valid && (cmd.op == rpf_pkg::CMD_REG_RD)
                      && (cmd.addr == rpf_pkg::QSTAT_OFS);

  // the controller may leave one idle cycle between two commands
  property p_reuse_set;
    cmd_valid && (cmd.op == rpf_pkg::CMD_REUSE)
      ##1 (is_rd_stat or (!cmd_valid ##1 is_rd_stat))
      |=> rd_valid && rd_data[rpf_pkg::REUSE_BIT];
  endproperty
  a_reuse_set: assert property (p_reuse_set)
    else $error("reuse flag not set by repeat command");

  property p_reuse_clr;
    cmd_valid && ((cmd.op == rpf_pkg::CMD_W_TX)
                  || (cmd.op == rpf_pkg::CMD_FLUSH_TX))
      |=> !st.reuse;
  endproperty
  a_reuse_clr: assert property (p_reuse_clr)
    else $error("reuse flag survived payload write or flush");

  property p_tx_flags;
    is_rd_stat |=> rd_data[rpf_pkg::TX_FULL_BIT] == ($past(st.txn) == 2'h3)
                && rd_data[rpf_pkg::TX_EMPTY_BIT] == ($past(st.txn) == 2'h0);
  endproperty
  a_tx_flags: assert property (p_tx_flags)
    else $error("transmit full or empty flag wrong");

  property p_rx_flags;
    is_rd_stat |=> rd_data[rpf_pkg::RX_FULL_BIT] == ($past(st.rxn) == 2'h3)
                && rd_data[rpf_pkg::RX_EMPTY_BIT] == ($past(st.rxn) == 2'h0);
  endproperty
  a_rx_flags: assert property (p_rx_flags)
    else $error("receive full or empty flag wrong");

  property p_flush_empty;
    cmd_valid && (cmd.op == rpf_pkg::CMD_FLUSH_TX)
      ##1 (is_rd_stat or (!cmd_valid ##1 is_rd_stat))
      |=> rd_data[rpf_pkg::TX_EMPTY_BIT] && !rd_data[rpf_pkg::TX_FULL_BIT];
  endproperty
  a_flush_empty: assert property (p_flush_empty)
    else $error("flush not seen by the next status read");

  property p_tx_drop;
    cmd_valid && (cmd.op == rpf_pkg::CMD_W_TX) && (st.txn == 2'h3)
      && !(tx_take && !rx_mode) |=> (st.txn == 2'h3) && $stable(st.txq);
  endproperty
  a_tx_drop: assert property (p_tx_drop)
    else $error("write to full transmit queue disturbed it");

  property p_rx_drop;
    rx_push && (st.rxn == 2'h3)
      && !(cmd_valid && (cmd.op == rpf_pkg::CMD_R_RX))
      && !(cmd_valid && (cmd.op == rpf_pkg::CMD_FLUSH_RX))
      |=> (st.rxn == 2'h3) && $stable(st.rxq);
  endproperty
  a_rx_drop: assert property (p_rx_drop)
    else $error("push to full receive queue disturbed it");

  property p_tx_rx_mode;
    rx_mode |=> !tx_out_valid;
  endproperty
  a_tx_rx_mode: assert property (p_tx_rx_mode)
    else $error("transmit payload drained in receive mode");

  property p_ack_tx_mode;
    !rx_mode |=> !ack_out_valid;
  endproperty
  a_ack_tx_mode: assert property (p_ack_tx_mode)
    else $error("acknowledgement payload drained in transmit mode");

  // a fourth write must not wrap the two-bit count back to empty
  property p_ack_cap;
    st.ackn == 2'h3 |=> st.ackn != 2'h0;
  endproperty
  a_ack_cap: assert property (p_ack_cap)
    else $error("acknowledgement queue wrapped past three");

  property p_ack_gate;
    cmd_valid && (cmd.op == rpf_pkg::CMD_W_ACK) && !ack_pay_en
      && !(ack_take && rx_mode) |=> $stable(st.ackn);
  endproperty
  a_ack_gate: assert property (p_ack_gate)
    else $error("acknowledgement payload taken while feature is off");

  property p_width_wr;
    cmd_valid && (cmd.op == rpf_pkg::CMD_REG_WR)
      && (cmd.addr == rpf_pkg::PIPE5_WIDTH_OFS)
      |=> pipe5_rx_width == $past(cmd.wdata[5:0]);
  endproperty
  a_width_wr: assert property (p_width_wr)
    else $error("pipe five width not stored");

  property p_width4_wr;
    cmd_valid && (cmd.op == rpf_pkg::CMD_REG_WR)
      && (cmd.addr == rpf_pkg::PIPE4_WIDTH_OFS)
      |=> pipe4_rx_width == $past(cmd.wdata[5:0]);
  endproperty
  a_width4_wr: assert property (p_width4_wr)
    else $error("pipe four width not stored");

  c_tx_full:   cover property (st.txn == 2'h3 ##1 tx_out_valid);
  c_reuse_rep: cover property (st.reuse && tx_out_valid);
  c_ack_out:   cover property (ack_out_valid && st.ackn != 2'h0);
  c_rx_full:   cover property (st.rxn == 2'h3 ##[1:20] rx_out_valid);
  c_reuse_end: cover property (st.reuse ##1 !st.reuse);

endmodule : rpf_queues

// *** pkg/rpf_pkg.sv ***
// shared constants, command encodings and carriers for the payload queues
package rpf_pkg;
  // register offsets on the command interface
  localparam logic [7:0] PIPE4_WIDTH_OFS = 8'h15;
  localparam logic [7:0] PIPE5_WIDTH_OFS = 8'h16;
  localparam logic [7:0] QSTAT_OFS       = 8'h17;
  // field layout
  localparam int         WIDTH_BITS      = 6;
  localparam logic [5:0] WIDTH_RST       = 6'h00;
  localparam int         REUSE_BIT       = 6;
  localparam int         TX_FULL_BIT     = 5;
  localparam int         TX_EMPTY_BIT    = 4;
  localparam int         RX_FULL_BIT     = 1;
  localparam int         RX_EMPTY_BIT    = 0;
  // queue geometry
  localparam int         QDEPTH          = 3;
  localparam logic [1:0] QFULL           = 2'h3;
  localparam int         PLD_BITS        = 256;
  localparam int         MAX_PLD_BYTES   = 32;
  localparam logic [2:0] LAST_PIPE       = 3'h5;
  // least chip-enable pulse for a repeat, kept by the controller
  localparam int         CLK_NS          = 10;
  localparam int         REUSE_CE_MIN_NS = 10000;
  localparam int         REUSE_CE_CYC    =
    (REUSE_CE_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [8:0] {
    CMD_NOP      = 9'h001,
    CMD_REG_RD   = 9'h002,
    CMD_REG_WR   = 9'h004,
    CMD_W_TX     = 9'h008,
    CMD_W_ACK    = 9'h010,
    CMD_REUSE    = 9'h020,
    CMD_FLUSH_TX = 9'h040,
    CMD_FLUSH_RX = 9'h080,
    CMD_R_RX     = 9'h100
  } rpf_op_t;

  typedef struct packed {
    logic [PLD_BITS-1:0] pld;
    logic [5:0]          len;
    logic [2:0]          pipe;
  } rpf_entry_t;

  typedef struct packed {
    rpf_op_t    op;
    logic [7:0] addr;
    logic [7:0] wdata;
    rpf_entry_t pld;
  } rpf_cmd_t;

  typedef struct packed {
    rpf_entry_t [QDEPTH-1:0] txq;
    logic [1:0]              txn;
    rpf_entry_t [QDEPTH-1:0] rxq;
    logic [1:0]              rxn;
    rpf_entry_t [QDEPTH-1:0] ackq;
    logic [1:0]              ackn;
    logic                    reuse;
    rpf_entry_t              last;
    logic [5:0]              p4w;
    logic [5:0]              p5w;
    logic [7:0]              rd_data;
    logic                    rd_valid;
    rpf_entry_t              rx_out;
    logic                    rx_out_valid;
    rpf_entry_t              tx_out;
    logic                    tx_out_valid;
    rpf_entry_t              ack_out;
    logic                    ack_out_valid;
  } rpf_state_t;
endpackage : rpf_pkg

// *** testbench/rpf_ctrl_model.sv ***
// controller model: one command per strobe on the command port
`timescale 1ns/1ps
module rpf_ctrl_model (
  // clock
  input  wire logic         clk,
  // command port
  output logic              cmd_valid,
  output rpf_pkg::rpf_cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end
  // idle bus shows inverted bits so unstrobed sampling sees junk
  task automatic issue(input rpf_pkg::rpf_op_t o, input logic [7:0] a,
                       input logic [7:0] d, input rpf_pkg::rpf_entry_t e);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd       = '{o, a, d, e};
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd       = rpf_pkg::rpf_cmd_t'(~cmd);
  endtask : issue
endmodule : rpf_ctrl_model

// *** testbench/radio_payload_fifo_status_tb_top.sv ***
// self-checking bench for the payload queues and queue status
`timescale 1ns/1ps
module radio_payload_fifo_status_tb_top;
  logic                clk, sys_rst, cmd_valid, rd_valid, rx_out_valid;
  logic                rx_mode, ack_pay_en, rx_push, ack_take, tx_take;
  logic                ack_out_valid, tx_out_valid, reuse;
  logic [7:0]          rd_data;
  logic [5:0]          pipe4_rx_width, pipe5_rx_width;
  logic [2:0]          ack_pipe;
  logic [31:0]         lfsr_s;
  int                  n_errors, comparisons, cycles;
  rpf_pkg::rpf_cmd_t   cmd;
  rpf_pkg::rpf_entry_t rx_out, rx_in, ack_out, tx_out, last;
  rpf_pkg::rpf_entry_t tx_q[$], rx_q[$], ack_q[$], exp_ent[$];
  logic [7:0]          exp_rd[$];
  rpf_queues u_rpf_queues (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .rd_data(rd_data),
    .rd_valid(rd_valid), .rx_out(rx_out), .rx_out_valid(rx_out_valid),
    .rx_mode(rx_mode), .ack_pay_en(ack_pay_en),
    .pipe4_rx_width(pipe4_rx_width), .pipe5_rx_width(pipe5_rx_width),
    .rx_push(rx_push), .rx_in(rx_in), .ack_take(ack_take),
    .ack_pipe(ack_pipe), .ack_out(ack_out), .ack_out_valid(ack_out_valid),
    .tx_take(tx_take), .tx_out(tx_out), .tx_out_valid(tx_out_valid));
  rpf_ctrl_model u_rpf_ctrl_model (.clk(clk), .cmd_valid(cmd_valid),
    .cmd(cmd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [264:0] seen, input logic [264:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t value mismatch", $time);
    end
  endtask : chk
  // an unexpected answer is compared against its own inverse
  task automatic got(input logic [264:0] seen, input logic is_rd);
    logic [264:0] e;
    if (is_rd && exp_rd.size() > 0) e = {257'h0, exp_rd.pop_front()};
    else if (!is_rd && exp_ent.size() > 0) e = exp_ent.pop_front();
    else e = ~seen;
    chk(seen, e);
  endtask : got
  always @(negedge clk) begin
    if (rd_valid === 1'b1) got({257'h0, rd_data}, 1'b1);
    if (rx_out_valid === 1'b1) got(rx_out, 1'b0);
    if (tx_out_valid === 1'b1) got(tx_out, 1'b0);
    if (ack_out_valid === 1'b1) got(ack_out, 1'b0);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end
  function automatic logic [31:0] lfsr();
    lfsr_s = {lfsr_s[30:0], 1'b0} ^ (lfsr_s[31] ? 32'h04c11db7 : 32'h0);
    return lfsr_s;
  endfunction : lfsr
  function automatic rpf_pkg::rpf_entry_t rnd(input logic [2:0] p);
    rpf_pkg::rpf_entry_t e;
    for (int i = 0; i < 8; i++)
      e.pld[i*32 +: 32] = lfsr();
    e.len  = 6'(lfsr() % 32 + 1);
    e.pipe = p;
    return e;
  endfunction : rnd
  function automatic logic [7:0] stat();
    return {1'b0, reuse, tx_q.size() == rpf_pkg::QDEPTH, tx_q.size() == 0,
      2'b00, rx_q.size() == rpf_pkg::QDEPTH, rx_q.size() == 0};
  endfunction : stat
  task automatic go(input rpf_pkg::rpf_op_t o, input logic [7:0] a,
                    input logic [7:0] d, input rpf_pkg::rpf_entry_t e);
    u_rpf_ctrl_model.issue(o, a, d, e);
  endtask : go
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_rd.push_back(x);
    go(rpf_pkg::CMD_REG_RD, a, 8'h00, '0);
  endtask : rd
  task automatic radio(input logic [2:0] s, input rpf_pkg::rpf_entry_t e,
                       input logic [2:0] p);
    @(negedge clk);
    {rx_push, tx_take, ack_take} = s;
    rx_in    = e;
    ack_pipe = p;
    @(negedge clk);
    {rx_push, tx_take, ack_take} = 3'h0;
    rx_in    = rpf_pkg::rpf_entry_t'(~rx_in);
    ack_pipe = ~ack_pipe;
  endtask : radio
  task automatic wtx(input rpf_pkg::rpf_entry_t e);
    if (tx_q.size() < rpf_pkg::QDEPTH) tx_q.push_back(e);
    reuse = 1'b0;
    go(rpf_pkg::CMD_W_TX, 8'h00, 8'h00, e);
  endtask : wtx
  task automatic take_tx();
    if (!rx_mode && (reuse || tx_q.size() > 0)) begin
      if (!reuse) last = tx_q.pop_front();
      exp_ent.push_back(last);
    end
    radio(3'h2, '0, 3'h0);
    // a repeat keeps chip enable up for the least pulse before the next
    if (reuse) repeat (rpf_pkg::REUSE_CE_CYC) @(negedge clk);
  endtask : take_tx
  task automatic wack(input rpf_pkg::rpf_entry_t e);
    if (ack_pay_en && ack_q.size() < rpf_pkg::QDEPTH &&
        e.pipe <= rpf_pkg::LAST_PIPE) ack_q.push_back(e);
    go(rpf_pkg::CMD_W_ACK, 8'h00, 8'h00, e);
  endtask : wack
  task automatic take_ack(input logic [2:0] p);
    int i;
    i = -1;
    foreach (ack_q[k])
      if (i < 0 && ack_q[k].pipe === p) i = k;
    if (rx_mode && i >= 0) begin
      exp_ent.push_back(ack_q[i]);
      ack_q.delete(i);
    end
    radio(3'h1, '0, p);
  endtask : take_ack
  initial begin
    {sys_rst, reuse, rx_mode, ack_pay_en} = 4'h8;
    {rx_push, tx_take, ack_take, ack_pipe} = 6'h0;
    {n_errors, comparisons, cycles} = '0;
    {rx_in, last} = '0;
    lfsr_s = 32'hb7392782;
    repeat (20) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    rd(rpf_pkg::QSTAT_OFS, stat());
    rd(rpf_pkg::PIPE4_WIDTH_OFS, 8'h00);
    rd(rpf_pkg::PIPE5_WIDTH_OFS, 8'h00);
    rd(8'h20, 8'h00);
    go(rpf_pkg::CMD_REG_WR, rpf_pkg::PIPE4_WIDTH_OFS, 8'h20, '0);
    go(rpf_pkg::CMD_REG_WR, rpf_pkg::PIPE5_WIDTH_OFS, 8'h01, '0);
    go(rpf_pkg::CMD_REG_WR, 8'h20, 8'h3f, '0);
    rd(rpf_pkg::PIPE4_WIDTH_OFS, 8'h20);
    rd(rpf_pkg::PIPE5_WIDTH_OFS, 8'h01);
    chk({pipe5_rx_width, pipe4_rx_width}, 12'h060);
    rx_mode = 1'b1;
    repeat (4) begin
      wtx(rnd(3'h0));
      rd(rpf_pkg::QSTAT_OFS, stat());
    end
    take_tx();
    rx_mode = 1'b0;
    take_tx();
    go(rpf_pkg::CMD_REUSE, 8'h00, 8'h00, '0);
    reuse = 1'b1;
    rd(rpf_pkg::QSTAT_OFS, stat());
    repeat (2) take_tx();
    wtx(rnd(3'h1));
    rd(rpf_pkg::QSTAT_OFS, stat());
    go(rpf_pkg::CMD_REUSE, 8'h00, 8'h00, '0);
    go(rpf_pkg::CMD_FLUSH_TX, 8'h00, 8'h00, '0);
    reuse = 1'b0;
    tx_q.delete();
    rd(rpf_pkg::QSTAT_OFS, stat());
    take_tx();
    repeat (4) begin
      if (rx_q.size() < rpf_pkg::QDEPTH) rx_q.push_back(rnd(3'h3));
      radio(3'h4, rx_q[rx_q.size()-1], 3'h0);
      rd(rpf_pkg::QSTAT_OFS, stat());
    end
    repeat (4) begin
      if (rx_q.size() > 0) exp_ent.push_back(rx_q.pop_front());
      go(rpf_pkg::CMD_R_RX, 8'h00, 8'h00, '0);
    end
    radio(3'h4, rnd(3'h4), 3'h0);
    go(rpf_pkg::CMD_FLUSH_RX, 8'h00, 8'h00, '0);
    rd(rpf_pkg::QSTAT_OFS, stat());
    {rx_mode, ack_pay_en} = 2'h3;
    wack(rnd(3'h2));
    wack(rnd(3'h4));
    wack(rnd(3'h2));
    wack(rnd(3'h1));
    take_ack(3'h2);
    take_ack(3'h2);
    take_ack(3'h4);
    take_ack(3'h1);
    wack(rnd(3'h6));
    take_ack(3'h6);
    ack_pay_en = 1'b0;
    wack(rnd(3'h3));
    take_ack(3'h3);
    {rx_mode, ack_pay_en} = 2'h1;
    wack(rnd(3'h5));
    take_ack(3'h5);
    rx_mode = 1'b1;
    take_ack(3'h5);
    repeat (3) @(negedge clk);
    chk(exp_rd.size() + exp_ent.size(), 0);
    close_out();
  end
endmodule : radio_payload_fifo_status_tb_top
